// >>> logic/cpp_pkg.sv
// Shared constants and types of the phase-sequenced 8-bit core.
// Assumes one synchronous clock domain and an AXI4-Lite control port.
package cpp_pkg;

	// Instruction cycle made of four phases, one per core clock.
	localparam int PHASES_PER_CYCLE = 4;
	typedef enum logic [1:0] {
		PH_ONE = 2'b00,
		PH_TWO = 2'b01,
		PH_THREE = 2'b10,
		PH_FOUR = 2'b11
	} cpp_phase_t;

	// Opcode lives in the top nibble of the 12-bit instruction word.
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ADD = 4'h1,
		OP_SUB = 4'h2,
		OP_AND = 4'h3,
		OP_OR = 4'h4,
		OP_XOR = 4'h5,
		OP_MOVF = 4'h6,
		OP_MOVWF = 4'h7,
		OP_RRF = 4'h8,
		OP_RLF = 4'h9,
		OP_COMF = 4'hA,
		OP_INCF = 4'hB,
		OP_ADDLW = 4'hC,
		OP_ANDLW = 4'hD,
		OP_MOVLW = 4'hE,
		OP_JUMP = 4'hF
	} cpp_op_t;

	typedef struct packed {
		logic [7:0] val;
		logic c;
		logic nc;
		logic upd_c;
		logic upd_nc;
		logic upd_z;
	} cpp_alu_t;

	localparam logic [11:0] NOP_WORD = 12'h000;
	localparam logic [11:0] PTR_RST = 12'h000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] FSR_RST = 8'hE0;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam int DEST_BIT = 5;
	localparam int C_BIT = 0;
	localparam int NC_BIT = 1;
	localparam int Z_BIT = 2;

	// Special registers inside the data register file space.
	localparam logic [4:0] SFR_INDIRECT = 5'h00;
	localparam logic [4:0] SFR_PTR_LOW = 5'h02;
	localparam logic [4:0] SFR_FLAGS = 5'h03;
	localparam logic [4:0] SFR_SELECT = 5'h04;

	// AXI4-Lite register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_FETCH = 8'h08;
	localparam logic [7:0] REG_ACC = 8'h0C;
	localparam logic [7:0] REG_INSN = 8'h10;
	localparam logic CTRL_RUN_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> logic/cpp_regfile.sv
// Data register file of the core: 32 bytes, one write and one read port.
// Assumes the core issues the read one cycle before it needs the byte.
`timescale 1ns/1ns
`default_nettype none
module cpp_regfile
(
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [7:0] wdata,
	// Read port
	input wire logic re,
	input wire logic [4:0] raddr,
	output logic [7:0] rdata_r
);
	logic [7:0] mem [32];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (re)
			rdata_r <= mem[raddr];
	end
endmodule
`default_nettype wire

// >>> logic/cpp_core.sv
// Phase-sequenced two-stage core with an 8-bit ALU and AXI4-Lite control.
// Assumes program memory answers within three core clocks on prog_data.
//
// Overview of operation
// - Core clock is counted into four ordered, non-overlapping phases.
// - An instruction cycle is exactly four phases; all sequencing uses them.
// - Fetch pointer increments in phase one, opening each fetch cycle.
// - Fetched word enters the instruction latch in phase four.
// - Latched instruction decodes and executes in phases two to four next cycle.
// - File operand is read in phase two, result written in phase four.
// - Next fetch overlaps current execution, giving one instruction per cycle.
// - Instructions that change the fetch pointer take two instruction cycles.
// - Instructions are single 12-bit words on a dedicated program bus.
// - Program and data use separate buses, usable in the same cycle.
// - Every instruction finishes in one cycle except program branches.
// - ALU is 8 bits: add, subtract, shift and logical operations.
// - Arithmetic is two's complement.
// - Two-operand ops pair the accumulator with a file byte or literal.
// - Single-operand ops work on a file byte, result to the accumulator or the file.
// - Accumulator is 8 bits and has no register file address.
// - ALU updates carry, nibble carry and zero flags per instruction.
// - Subtraction carry and nibble carry are inverted borrows.
// - Special registers, fetch pointer low byte included, sit in file space.
// - Fetch pointer is 12 bits wide.
`timescale 1ns/1ns
`default_nettype none
module cpp_core
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Program bus
	output logic [11:0] prog_addr,
	input wire logic [11:0] prog_data,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	cpp_pkg::cpp_phase_t phase_r;
	cpp_pkg::cpp_op_t op;
	cpp_pkg::cpp_alu_t res_r;
	logic run_r;
	logic [11:0] fetch_pointer_r;
	logic [11:0] prog_addr_r;
	logic [11:0] instruction_latch_r;
	logic [7:0] acc_r;
	logic [7:0] fsr_r;
	logic [2:0] flags_r;
	logic [7:0] opnd;
	logic [7:0] rf_rdata_r;
	logic [4:0] faddr;
	logic [4:0] eff;
	logic dest_file;
	logic wr_file;
	logic rf_re;
	logic rf_we;
	logic branch_now;
	logic p2;
	logic p3;
	logic p4;

	function automatic logic uses_file(input cpp_pkg::cpp_op_t o);
		return o inside {cpp_pkg::OP_ADD, cpp_pkg::OP_SUB, cpp_pkg::OP_AND,
			cpp_pkg::OP_OR, cpp_pkg::OP_XOR, cpp_pkg::OP_MOVF, cpp_pkg::OP_RRF,
			cpp_pkg::OP_RLF, cpp_pkg::OP_COMF, cpp_pkg::OP_INCF};
	endfunction

	function automatic logic writes_file(input cpp_pkg::cpp_op_t o, input logic d);
		return (uses_file(o) && d) || (o == cpp_pkg::OP_MOVWF);
	endfunction

	function automatic cpp_pkg::cpp_alu_t alu(input cpp_pkg::cpp_op_t o,
		input logic [7:0] a, input logic [7:0] f, input logic [7:0] lit,
		input logic cin);
		logic [8:0] s;
		logic [4:0] n;
		cpp_pkg::cpp_alu_t r;
		s = 9'h000;
		n = 5'h00;
		r = '0;
		r.upd_z = 1'b1;
		unique case (o)
			cpp_pkg::OP_ADD, cpp_pkg::OP_ADDLW:
			begin
				s = {1'b0, (o == cpp_pkg::OP_ADD) ? f : lit} + {1'b0, a};
				n = {1'b0, (o == cpp_pkg::OP_ADD) ? f[3:0] : lit[3:0]} + {1'b0, a[3:0]};
				r.val = s[7:0];
				r.c = s[8];
				r.nc = n[4];
				r.upd_c = 1'b1;
				r.upd_nc = 1'b1;
			end
			cpp_pkg::OP_SUB:
			begin
				// Two's complement f - acc; a set carry means no borrow.
				s = {1'b0, f} - {1'b0, a};
				n = {1'b0, f[3:0]} - {1'b0, a[3:0]};
				r.val = s[7:0];
				r.c = ~s[8];
				r.nc = ~n[4];
				r.upd_c = 1'b1;
				r.upd_nc = 1'b1;
			end
			cpp_pkg::OP_AND: r.val = f & a;
			cpp_pkg::OP_OR: r.val = f | a;
			cpp_pkg::OP_XOR: r.val = f ^ a;
			cpp_pkg::OP_ANDLW: r.val = lit & a;
			cpp_pkg::OP_MOVF: r.val = f;
			cpp_pkg::OP_COMF: r.val = ~f;
			cpp_pkg::OP_INCF: r.val = f + 8'h01;
			cpp_pkg::OP_RRF:
			begin
				r.val = {cin, f[7:1]};
				r.c = f[0];
				r.upd_c = 1'b1;
				r.upd_z = 1'b0;
			end
			cpp_pkg::OP_RLF:
			begin
				r.val = {f[6:0], cin};
				r.c = f[7];
				r.upd_c = 1'b1;
				r.upd_z = 1'b0;
			end
			cpp_pkg::OP_MOVWF:
			begin
				r.val = a;
				r.upd_z = 1'b0;
			end
			cpp_pkg::OP_MOVLW:
			begin
				r.val = lit;
				r.upd_z = 1'b0;
			end
			cpp_pkg::OP_NOP, cpp_pkg::OP_JUMP:
			begin
				r.val = a;
				r.upd_z = 1'b0;
			end
		endcase
		return r;
	endfunction

	// Decode of the word held in the instruction latch.
	assign op = cpp_pkg::cpp_op_t'(instruction_latch_r[11:8]);
	assign faddr = instruction_latch_r[4:0];
	assign dest_file = instruction_latch_r[cpp_pkg::DEST_BIT];
	assign eff = (faddr == cpp_pkg::SFR_INDIRECT) ? fsr_r[4:0] : faddr;
	assign wr_file = writes_file(op, dest_file);
	assign p2 = run_r && (phase_r == cpp_pkg::PH_TWO);
	assign p3 = run_r && (phase_r == cpp_pkg::PH_THREE);
	assign p4 = run_r && (phase_r == cpp_pkg::PH_FOUR);
	assign rf_re = p2 && uses_file(op);
	assign rf_we = p4 && wr_file && !(eff inside {cpp_pkg::SFR_PTR_LOW,
		cpp_pkg::SFR_FLAGS, cpp_pkg::SFR_SELECT});
	// Writing the low pointer byte is a branch just like a jump.
	assign branch_now = p4 && ((op == cpp_pkg::OP_JUMP) ||
		(wr_file && eff == cpp_pkg::SFR_PTR_LOW));
	assign prog_addr = prog_addr_r;

	// Special registers overlay the file; the accumulator is not reachable here.
	always_comb
	begin
		unique case (eff)
			cpp_pkg::SFR_PTR_LOW: opnd = fetch_pointer_r[7:0];
			cpp_pkg::SFR_FLAGS: opnd = {5'h00, flags_r};
			cpp_pkg::SFR_SELECT: opnd = fsr_r;
			default: opnd = rf_rdata_r;
		endcase
	end

	// Data accesses use their own port, so they can coincide with a fetch.
	cpp_regfile u_rf
	(
		.clk(core_clk),
		.we(rf_we),
		.waddr(eff),
		.wdata(res_r.val),
		.re(rf_re),
		.raddr(eff),
		.rdata_r(rf_rdata_r)
	);

	// Phase sequencer; it only stands still while software holds run low.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			phase_r <= cpp_pkg::PH_ONE;
		else if (run_r)
			phase_r <= cpp_cpp_next(phase_r);
	end

	function automatic cpp_pkg::cpp_phase_t cpp_cpp_next(input cpp_pkg::cpp_phase_t p);
		return cpp_pkg::cpp_phase_t'(p + 2'b01);
	endfunction

	// Fetch pointer and program bus address.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			fetch_pointer_r <= cpp_pkg::PTR_RST;
			prog_addr_r <= cpp_pkg::PTR_RST;
		end
		else if (run_r && phase_r == cpp_pkg::PH_ONE)
		begin
			prog_addr_r <= fetch_pointer_r;
			fetch_pointer_r <= fetch_pointer_r + 12'h001;
		end
		else if (branch_now)
		begin
			if (op == cpp_pkg::OP_JUMP)
				fetch_pointer_r <= {4'h0, instruction_latch_r[7:0]};
			else
				fetch_pointer_r <= {fetch_pointer_r[11:8], res_r.val};
		end
	end

	// The fetch of the next word overlaps this execution; a branch flushes it.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			instruction_latch_r <= cpp_pkg::NOP_WORD;
		else if (branch_now)
			instruction_latch_r <= cpp_pkg::NOP_WORD;
		else if (p4)
			instruction_latch_r <= prog_data;
	end

	// ALU result forms in phase three from the operand read in phase two.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			res_r <= '0;
		else if (p3)
			res_r <= alu(op, acc_r, opnd, instruction_latch_r[7:0],
				flags_r[cpp_pkg::C_BIT]);
	end

	// Destination write and flag update in phase four.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			acc_r <= cpp_pkg::ACC_RST;
		else if (p4 && !wr_file && op != cpp_pkg::OP_JUMP)
			acc_r <= res_r.val;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			fsr_r <= cpp_pkg::FSR_RST;
		else if (p4 && wr_file && eff == cpp_pkg::SFR_SELECT)
			fsr_r <= res_r.val;
	end

	// An explicit write of the flag register wins over the ALU's own flags.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			flags_r <= cpp_pkg::FLAGS_RST;
		else if (p4 && wr_file && eff == cpp_pkg::SFR_FLAGS)
			flags_r <= res_r.val[2:0];
		else if (p4)
		begin
			if (res_r.upd_c)
				flags_r[cpp_pkg::C_BIT] <= res_r.c;
			if (res_r.upd_nc)
				flags_r[cpp_pkg::NC_BIT] <= res_r.nc;
			if (res_r.upd_z)
				flags_r[cpp_pkg::Z_BIT] <= (res_r.val == 8'h00);
		end
	end

	// AXI4-Lite write side: address and data are taken in either order.
	logic aw_held_r;
	logic w_held_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else if (aw_held_r && w_held_r)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	// Only the control word is writable; other offsets answer with an error.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= cpp_pkg::RESP_OKAY;
			run_r <= cpp_pkg::CTRL_RUN_RST;
		end
		else if (aw_held_r && w_held_r)
		begin
			bvalid_r <= 1'b1;
			if (awaddr_r[7:2] == cpp_pkg::REG_CTRL[7:2])
			begin
				bresp_r <= cpp_pkg::RESP_OKAY;
				if (wstrb_r[0])
					run_r <= wdata_r[0];
			end
			else
				bresp_r <= cpp_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	// AXI4-Lite read side.
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= cpp_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= cpp_pkg::RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				cpp_pkg::REG_CTRL: rdata_r <= {31'h0000_0000, run_r};
				cpp_pkg::REG_STATE: rdata_r <= {27'h000_0000, flags_r, phase_r};
				cpp_pkg::REG_FETCH: rdata_r <= {20'h0_0000, fetch_pointer_r};
				cpp_pkg::REG_ACC: rdata_r <= {16'h0000, fsr_r, acc_r};
				cpp_pkg::REG_INSN: rdata_r <= {20'h0_0000, instruction_latch_r};
				default:
				begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= cpp_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	a_phase_order:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		(run_r && phase_r == cpp_pkg::PH_ONE) |=> phase_r == cpp_pkg::PH_TWO)
	else $error("phase two did not follow phase one");

	a_cycle_length:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		(phase_r == cpp_pkg::PH_FOUR && run_r) ##1 run_r [*4]
		|-> phase_r == cpp_pkg::PH_FOUR)
	else $error("instruction cycle is not four phases");

	a_pointer_step:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		(run_r && phase_r == cpp_pkg::PH_ONE)
		|=> fetch_pointer_r == $past(fetch_pointer_r) + 12'h001)
	else $error("fetch pointer did not step in phase one");

	a_latch_fetch:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		(p4 && !branch_now) |=> instruction_latch_r == $past(prog_data))
	else $error("instruction latch missed the fetched word");

	// A software halt freezes the phases mid-cycle, so the read-phase and branch-flush checks stand down then.
	a_read_phase:
	assert property (@(posedge core_clk) disable iff (!rst_n || !run_r)
		rf_re |-> phase_r == cpp_pkg::PH_TWO ##2 (phase_r == cpp_pkg::PH_FOUR))
	else $error("operand read outside phase two");

	a_write_phase:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		rf_we |-> phase_r == cpp_pkg::PH_FOUR && $past(phase_r, 2) == cpp_pkg::PH_TWO)
	else $error("file write outside phase four");

	a_acc_update:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		(acc_r != $past(acc_r)) |-> $past(phase_r) == cpp_pkg::PH_FOUR)
	else $error("accumulator changed outside phase four");

	a_branch_flush:
	assert property (@(posedge core_clk) disable iff (!rst_n || !run_r)
		branch_now |=> instruction_latch_r == cpp_pkg::NOP_WORD
		##1 prog_addr_r == $past(fetch_pointer_r))
	else $error("branch did not flush and refetch");

	a_sub_borrow:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		(p3 && op == cpp_pkg::OP_SUB) |=> res_r.c == ($past(opnd) >= $past(acc_r)))
	else $error("subtract carry is not an inverted borrow");
endmodule
`default_nettype wire

// >>> bench/cpp_prog_mem.sv
// Program memory model that answers the core's program bus.
// Assumes the bench loads mem before it sets the core running.
`timescale 1ns/1ns
`default_nettype none
module cpp_prog_mem
(
	// Clock
	input wire logic clk,
	// When high the word settles only two edges after the address moves
	input wire logic slow,
	// Program bus
	input wire logic [11:0] addr,
	output logic [11:0] data
);
	logic [11:0] mem [0:4095];
	logic [11:0] last_addr_r = 12'h000;
	logic settled_r = 1'b0;
	initial
	begin
		foreach (mem[i])
			mem[i] = cpp_pkg::NOP_WORD;
	end
	always @(posedge clk)
	begin
		last_addr_r <= addr;
		settled_r <= (addr == last_addr_r);
	end
	// A word that has not settled shows the inverse of the old word for one edge,
	// then the inverse of the new word, which an early sample can never match by luck.
	always_comb
		data = (!slow || (addr == last_addr_r && settled_r)) ? mem[addr] : ~mem[last_addr_r];
endmodule
`default_nettype wire

// >>> bench/test_cpu_core_phase_pipeline_alu.sv
// Self-checking bench for the phase-sequenced core.
// Assumes cpp_core and the cpp_prog_mem model; registers go over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module test_cpu_core_phase_pipeline_alu;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic slow = 1'b0;
	logic [11:0] prog_addr;
	logic [11:0] prog_data;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int addr_q[$];
	int cyc_q[$];
	logic [11:0] seen_addr = 12'h000;
	logic [1:0] r;
	logic [31:0] d;
	logic [31:0] d2;

	cpp_core u_cpp_core (.core_clk, .rst_n, .prog_addr, .prog_data, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	cpp_prog_mem u_cpp_prog_mem (.clk(core_clk), .slow(slow), .addr(prog_addr),
		.data(prog_data));

	initial
	begin
		forever
			#2 core_clk = ~core_clk;
	end

	// Fetch addresses are logged at the falling edge, clear of the launch edge.
	always @(negedge core_clk)
	begin
		cyc <= cyc + 1;
		if (rst_n && prog_addr !== seen_addr)
		begin
			addr_q.push_back(prog_addr);
			cyc_q.push_back(cyc);
		end
		seen_addr <= prog_addr;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw;
		logic w;
		logic b;
		logic done;
		done = 1'b0;
		rs = 2'b11;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			if (b) rs = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			done = b;
		end
		check({31'h0, done}, 32'h1, "write answer");
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar;
		logic rd;
		logic done;
		done = 1'b0;
		rs = 2'b11;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			rd = s_axi_rvalid && s_axi_rready;
			if (rd) v = s_axi_rdata;
			if (rd) rs = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rd) s_axi_rready <= 1'b0;
			done = rd;
		end
		check({31'h0, done}, 32'h1, "read answer");
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask

	// Loads a program, starts the core and waits for nine fetch address moves.
	task automatic load_run(input logic [11:0] words[7], input logic s);
		do_reset();
		foreach (words[i])
			u_cpp_prog_mem.mem[i] = words[i];
		slow <= s;
		addr_q.delete();
		cyc_q.delete();
		axi_write(cpp_pkg::REG_CTRL, 32'h1, r);
		check({30'h0, r}, {30'h0, cpp_pkg::RESP_OKAY}, "run write resp");
		for (int i = 0; i < 200 && addr_q.size() < 9; i++)
			@(posedge core_clk);
	endtask

	task automatic test_reset_regs();
		axi_read(cpp_pkg::REG_CTRL, d, r);
		check(d, {31'h0, cpp_pkg::CTRL_RUN_RST}, "ctrl reset");
		axi_read(cpp_pkg::REG_STATE, d, r);
		check(d, 32'h0, "phase and flags reset");
		axi_read(cpp_pkg::REG_FETCH, d, r);
		check(d, {20'h0, cpp_pkg::PTR_RST}, "fetch pointer reset");
		axi_read(cpp_pkg::REG_ACC, d, r);
		check(d, {16'h0, cpp_pkg::FSR_RST, cpp_pkg::ACC_RST}, "acc reset");
		axi_read(cpp_pkg::REG_INSN, d, r);
		check(d, {20'h0, cpp_pkg::NOP_WORD}, "latch reset");
		axi_read(8'h14, d, r);
		check({30'h0, r}, {30'h0, cpp_pkg::RESP_SLVERR}, "unmapped read resp");
		check(d, 32'h0, "unmapped read data");
		axi_write(cpp_pkg::REG_STATE, 32'h1F, r);
		check({30'h0, r}, {30'h0, cpp_pkg::RESP_SLVERR}, "read-only write resp");
		repeat (20) @(posedge core_clk);
		check({20'h0, prog_addr}, 32'h0, "halted fetch");
	endtask

	// Slow memory, add with carries, flags read as a file byte, then a jump
	// whose prefetched word would spoil the accumulator if it ran.
	task automatic test_pipeline_add();
		int exp_a[9] = '{1, 2, 3, 4, 5, 6, 5, 6, 5};
		load_run('{12'hE05, 12'h730, 12'hEFB, 12'h110, 12'h603, 12'hF05, 12'hE77}, 1'b1);
		for (int i = 0; i < 9; i++)
			check(addr_q[i], exp_a[i], "fetch order");
		for (int i = 1; i < 9; i++)
			check(cyc_q[i] - cyc_q[i - 1], 4, "cycle length");
		axi_read(cpp_pkg::REG_ACC, d, r);
		check({24'h0, d[7:0]}, 32'h07, "flags via file");
		check({24'h0, d[7:0]}, 32'h07, "no discarded exec");
	endtask

	task automatic sub_case(input logic [11:0] lit_f, input logic [11:0] lit_a,
		input logic [7:0] exp_acc, input logic [2:0] exp_fl);
		load_run('{12'hE00 | lit_f, 12'h730, 12'hE00 | lit_a, 12'h210, 12'hF04, 12'hE77,
			12'h000}, 1'b0);
		axi_read(cpp_pkg::REG_ACC, d, r);
		check({24'h0, d[7:0]}, {24'h0, exp_acc}, "sub result");
		axi_read(cpp_pkg::REG_STATE, d, r);
		check({29'h0, d[4:2]}, {29'h0, exp_fl}, "sub flags");
	endtask

	// Literal, logical and shift operations; then indirect access, a select
	// pointer write and a branch made by writing the pointer low byte.
	task automatic test_more_ops();
		int exp_b[9] = '{1, 2, 3, 4, 5, 6, 7, 6, 7};
		load_run('{12'hE3C, 12'hD0F, 12'hC81, 12'h730, 12'h930, 12'h510, 12'hF06}, 1'b0);
		axi_read(cpp_pkg::REG_ACC, d, r);
		check({24'h0, d[7:0]}, 32'h97, "literal and shift result");
		axi_read(cpp_pkg::REG_STATE, d, r);
		check({29'h0, d[4:2]}, 32'h1, "shift carry kept");
		load_run('{12'hE11, 12'h724, 12'hEFF, 12'h720, 12'hB00, 12'hC06, 12'h722}, 1'b0);
		for (int i = 0; i < 9; i++)
			check(addr_q[i], exp_b[i], "pointer write branch");
		axi_read(cpp_pkg::REG_ACC, d, r);
		check(d, 32'h0000_1106, "indirect increment");
	endtask

	task automatic test_sub_halt();
		sub_case(12'h003, 12'h005, 8'hFE, 3'b000);
		sub_case(12'h013, 12'h004, 8'h0F, 3'b001);
		axi_write(cpp_pkg::REG_CTRL, 32'h0, r);
		axi_read(cpp_pkg::REG_FETCH, d, r);
		repeat (20) @(posedge core_clk);
		axi_read(cpp_pkg::REG_FETCH, d2, r);
		check(d2, d, "frozen pointer");
	endtask

	initial
	begin
		do_reset();
		test_reset_regs();
		test_pipeline_add();
		test_more_ops();
		test_sub_halt();
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
